// *** verilog/tsg_pkg.sv ***
// constants, codes and state encoding of the trip and start guard
package tsg_pkg;
    localparam int N_TERM_DEF = 5;
    localparam int HIST_DEPTH_DEF = 4;
    localparam int CODE_W = 8;
    // assignable input function codes
    localparam logic [CODE_W-1:0] FUNC_FAULT = 8'h0c;
    localparam logic [CODE_W-1:0] FUNC_GUARD = 8'h0d;
    // error codes shown on the display
    localparam logic [CODE_W-1:0] ERR_NONE = 8'h00;
    localparam logic [CODE_W-1:0] ERR_UV = 8'h09;
    localparam logic [CODE_W-1:0] ERR_FAULT = 8'h0c;
    localparam logic [CODE_W-1:0] ERR_GUARD = 8'h0d;
    // positions of the dedicated inputs above the terminals
    localparam int AUX_RUN = 0;
    localparam int AUX_RST = 1;
    localparam int AUX_KEY = 2;
    localparam int AUX_UV = 3;
    localparam int AUX_W = 4;
    // cycles after reset release before inputs are judged
    localparam int PWRUP_CYC = 3;
    localparam int PWRUP_W = 2;
    typedef enum logic [4:0] {
        ST_POWERUP = 5'b00001,
        ST_STOP = 5'b00010,
        ST_RUN = 5'b00100,
        ST_TRIP = 5'b01000,
        ST_CLEAR = 5'b10000
    } tsg_state_t;
endpackage

// *** verilog/tsg_if.sv ***
// synchronised input levels and rising edges between modules
`timescale 1ns/1ps
interface tsg_if #(
    parameter int W = 1
) ();
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    modport sync_mp (output lvl, output rise);
    modport core_mp (input lvl, input rise);
endinterface

// *** verilog/tsg_input_sync.sv ***
// two-flop synchroniser with rising edge detect per input
`timescale 1ns/1ps
module tsg_input_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // raw inputs
    input wire logic [W-1:0] raw,
    // synchronised outputs
    tsg_if.sync_mp sig
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    if (W < 1) begin : g_bad_w
        $error("W must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign sig.lvl = sync_q;
    assign sig.rise = sync_q & ~last_q;
endmodule // tsg_input_sync

// *** verilog/tsg_func_map.sv ***
// decodes per-terminal function codes into function masks
`timescale 1ns/1ps
module tsg_func_map #(
    parameter int N_TERM = 5
) (
    // function code of each terminal
    input wire logic [N_TERM*tsg_pkg::CODE_W-1:0] term_func,
    // terminals carrying each function
    output logic [N_TERM-1:0] ext_mask,
    output logic [N_TERM-1:0] guard_mask
);
    function automatic logic func_is(
        input logic [tsg_pkg::CODE_W-1:0] code,
        input logic [tsg_pkg::CODE_W-1:0] want
    );
        func_is = (code == want);
    endfunction

    if (N_TERM < 1) begin : g_bad_term
        $error("N_TERM must be at least 1");
    end

    for (genvar i = 0; i < N_TERM; i++) begin : g_term
        assign ext_mask[i] = func_is(
            term_func[i*tsg_pkg::CODE_W +: tsg_pkg::CODE_W],
            tsg_pkg::FUNC_FAULT);
        assign guard_mask[i] = func_is(
            term_func[i*tsg_pkg::CODE_W +: tsg_pkg::CODE_W],
            tsg_pkg::FUNC_GUARD);
    end
endmodule // tsg_func_map

// *** verilog/tsg_trip_guard.sv ***
// external trip latch and power-up start guard of the drive
`timescale 1ns/1ps
module tsg_trip_guard #(
    parameter int N_TERM = tsg_pkg::N_TERM_DEF,
    parameter int HIST_DEPTH = tsg_pkg::HIST_DEPTH_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // intelligent input terminals and their function codes
    input wire logic [N_TERM-1:0] term_in,
    input wire logic [N_TERM*tsg_pkg::CODE_W-1:0] term_func,
    // commands and faults
    input wire logic run_cmd,
    input wire logic reset_terminal_input,
    input wire logic keypad_reset,
    input wire logic uv_fault,
    // drive status
    output logic drive_en,
    output logic coast,
    output logic alarm_out,
    output logic guard_active,
    output logic [tsg_pkg::CODE_W-1:0] err_code,
    // trip history, newest in the lowest slot
    output logic [HIST_DEPTH*tsg_pkg::CODE_W-1:0] hist_flat,
    output logic [$clog2(HIST_DEPTH+1)-1:0] hist_count
);
    localparam int SW = N_TERM + tsg_pkg::AUX_W;
    localparam int HCW = $clog2(HIST_DEPTH + 1);

    if (N_TERM < 1 || N_TERM > 16) begin : g_bad_term
        $error("N_TERM must lie in 1..16");
    end
    if (HIST_DEPTH < 1 || HIST_DEPTH > 64) begin : g_bad_hist
        $error("HIST_DEPTH must lie in 1..64");
    end

    tsg_if #(.W(SW)) sig ();

    tsg_input_sync #(.W(SW)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .raw({uv_fault, keypad_reset, reset_terminal_input, run_cmd,
              term_in}),
        .sig(sig)
    );

    logic [N_TERM-1:0] ext_mask;
    logic [N_TERM-1:0] guard_mask;

    tsg_func_map #(.N_TERM(N_TERM)) u_map (
        .term_func(term_func),
        .ext_mask(ext_mask),
        .guard_mask(guard_mask)
    );

    logic external_fault_input;
    logic powerup_start_guard;
    logic run_lvl;
    logic rst_cmd;
    logic uv_lvl;
    // edge only, so a held contact cannot re-trip after a reset
    assign external_fault_input =
        |(sig.rise[N_TERM-1:0] & ext_mask);
    assign powerup_start_guard =
        |(sig.lvl[N_TERM-1:0] & guard_mask);
    assign run_lvl = sig.lvl[N_TERM + tsg_pkg::AUX_RUN];
    assign rst_cmd = sig.lvl[N_TERM + tsg_pkg::AUX_RST]
                   | sig.lvl[N_TERM + tsg_pkg::AUX_KEY];
    assign uv_lvl = sig.lvl[N_TERM + tsg_pkg::AUX_UV];

    tsg_pkg::tsg_state_t state_q;
    tsg_pkg::tsg_state_t state_d;
    logic [tsg_pkg::CODE_W-1:0] err_q;
    logic [tsg_pkg::CODE_W-1:0] err_d;
    logic alarm_q;
    logic uv_origin_q;
    logic [tsg_pkg::PWRUP_W-1:0] pwr_cnt_q;
    logic pwr_done;
    logic trip_set;
    logic [tsg_pkg::CODE_W-1:0] trip_code;
    logic hist_clr;

    // waits out the synchroniser so power-up sees the true run level
    assign pwr_done =
        (pwr_cnt_q == tsg_pkg::PWRUP_W'(tsg_pkg::PWRUP_CYC - 1));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwr_cnt_q <= '0;
        end else if (state_q == tsg_pkg::ST_POWERUP && !pwr_done) begin
            pwr_cnt_q <= pwr_cnt_q + tsg_pkg::PWRUP_W'(1);
        end
    end

    always_comb begin
        state_d = state_q;
        trip_set = 1'b0;
        trip_code = tsg_pkg::ERR_NONE;
        unique case (state_q)
            tsg_pkg::ST_POWERUP: begin
                if (pwr_done) begin
                    if (run_lvl && powerup_start_guard) begin
                        state_d = tsg_pkg::ST_TRIP;
                        trip_set = 1'b1;
                        trip_code = tsg_pkg::ERR_GUARD;
                    end else if (run_lvl) begin
                        state_d = tsg_pkg::ST_RUN;
                    end else begin
                        state_d = tsg_pkg::ST_STOP;
                    end
                end
            end
            tsg_pkg::ST_STOP, tsg_pkg::ST_RUN: begin
                if (external_fault_input) begin
                    // output off and coasting from this edge on
                    state_d = tsg_pkg::ST_TRIP;
                    trip_set = 1'b1;
                    trip_code = tsg_pkg::ERR_FAULT;
                end else if (uv_lvl) begin
                    state_d = tsg_pkg::ST_TRIP;
                    trip_set = 1'b1;
                    trip_code = tsg_pkg::ERR_UV;
                end else if (run_lvl) begin
                    state_d = tsg_pkg::ST_RUN;
                end else begin
                    state_d = tsg_pkg::ST_STOP;
                end
            end
            tsg_pkg::ST_TRIP: begin
                // fault input level is not looked at here
                if (rst_cmd) begin
                    state_d = tsg_pkg::ST_CLEAR;
                end else if (err_q == tsg_pkg::ERR_GUARD && !run_lvl) begin
                    state_d = tsg_pkg::ST_STOP;
                end
            end
            tsg_pkg::ST_CLEAR: begin
                if (!rst_cmd) begin
                    if (uv_origin_q && run_lvl && powerup_start_guard) begin
                        state_d = tsg_pkg::ST_TRIP;
                        trip_set = 1'b1;
                        trip_code = tsg_pkg::ERR_GUARD;
                    end else if (run_lvl) begin
                        // a reset counts as the intervention
                        state_d = tsg_pkg::ST_RUN;
                    end else begin
                        state_d = tsg_pkg::ST_STOP;
                    end
                end
            end
            default: begin
                state_d = tsg_pkg::ST_STOP;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= tsg_pkg::ST_POWERUP;
        end else begin
            state_q <= state_d;
        end
    end

    always_comb begin
        if (trip_set) begin
            err_d = trip_code;
        end else if (state_d == tsg_pkg::ST_TRIP) begin
            err_d = err_q;
        end else begin
            err_d = tsg_pkg::ERR_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err_q <= tsg_pkg::ERR_NONE;
        end else begin
            err_q <= err_d;
        end
    end

    // registered with the state, so alarm and trip rise together
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= (state_d == tsg_pkg::ST_TRIP);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            uv_origin_q <= 1'b0;
        end else if (state_q == tsg_pkg::ST_TRIP &&
                     state_d == tsg_pkg::ST_CLEAR) begin
            uv_origin_q <= (err_q == tsg_pkg::ERR_UV);
        end
    end

    // trip history; a trip in the clearing cycle is kept
    logic [tsg_pkg::CODE_W-1:0] hist_q [HIST_DEPTH];
    logic [HCW-1:0] hist_cnt_q;

    assign hist_clr = (state_q == tsg_pkg::ST_TRIP) &&
                      (state_d == tsg_pkg::ST_CLEAR);

    for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                hist_q[i] <= tsg_pkg::ERR_NONE;
            end else if (trip_set) begin
                if (i == 0) begin
                    hist_q[i] <= trip_code;
                end else begin
                    hist_q[i] <= hist_q[(i == 0) ? 0 : i-1];
                end
            end else if (hist_clr) begin
                hist_q[i] <= tsg_pkg::ERR_NONE;
            end
        end
        assign hist_flat[i*tsg_pkg::CODE_W +: tsg_pkg::CODE_W] = hist_q[i];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hist_cnt_q <= '0;
        end else if (trip_set) begin
            if (hist_cnt_q != HCW'(HIST_DEPTH)) begin
                hist_cnt_q <= hist_cnt_q + HCW'(1);
            end
        end else if (hist_clr) begin
            hist_cnt_q <= '0;
        end
    end

    assign drive_en = (state_q == tsg_pkg::ST_RUN);
    assign coast = (state_q == tsg_pkg::ST_TRIP);
    assign alarm_out = alarm_q;
    assign err_code = err_q;
    assign guard_active = powerup_start_guard;
    assign hist_count = hist_cnt_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_fault_in_service;
        (state_q == tsg_pkg::ST_STOP || state_q == tsg_pkg::ST_RUN) &&
        external_fault_input;
    endsequence
    sequence s_tripped(logic [tsg_pkg::CODE_W-1:0] c);
        state_q == tsg_pkg::ST_TRIP && err_code == c && alarm_out &&
        !drive_en;
    endsequence
    sequence s_run_hit;
        state_q == tsg_pkg::ST_RUN ##0 external_fault_input;
    endsequence
    sequence s_pwr_judge;
        state_q == tsg_pkg::ST_POWERUP && pwr_done && run_lvl;
    endsequence

    a_fault_trip_code: assert property (
        s_fault_in_service |=> s_tripped(tsg_pkg::ERR_FAULT))
        else $error("external fault did not trip with code 12");
    a_fault_edge_only: assert property (
        state_q == tsg_pkg::ST_STOP && !external_fault_input && !uv_lvl
        |=> err_code == tsg_pkg::ERR_NONE)
        else $error("trip taken without a fault edge");
    a_trip_holds: assert property (
        state_q == tsg_pkg::ST_TRIP && err_code == tsg_pkg::ERR_FAULT &&
        !rst_cmd |=> state_q == tsg_pkg::ST_TRIP && $stable(err_code))
        else $error("external trip left without a reset");
    a_reset_clears: assert property (
        state_q == tsg_pkg::ST_TRIP && rst_cmd
        |=> state_q == tsg_pkg::ST_CLEAR && !alarm_out &&
            err_code == tsg_pkg::ERR_NONE)
        else $error("reset did not clear alarm and error");
    a_alarm_at_once: assert property (
        s_run_hit |=> alarm_out && coast ##1 alarm_out)
        else $error("alarm not raised at once on trip in run");
    a_release_runs: assert property (
        state_q == tsg_pkg::ST_CLEAR && !rst_cmd && !uv_origin_q &&
        run_lvl |=> drive_en)
        else $error("release with run held did not restart");
    a_hist_kept: assert property (
        state_q == tsg_pkg::ST_TRIP && !rst_cmd
        |=> hist_count == $past(hist_count) && hist_count != '0)
        else $error("trip history changed before a reset");
    a_guard_blocks: assert property (
        s_pwr_judge ##0 powerup_start_guard
        |=> s_tripped(tsg_pkg::ERR_GUARD))
        else $error("guarded power-up did not trip with code 13");
    a_noguard_runs: assert property (
        s_pwr_judge ##0 !powerup_start_guard |=> drive_en)
        else $error("unguarded power-up did not start");
    a_uv_guard: assert property (
        state_q == tsg_pkg::ST_CLEAR && !rst_cmd && uv_origin_q &&
        run_lvl && powerup_start_guard |=> s_tripped(tsg_pkg::ERR_GUARD))
        else $error("guard check skipped after undervoltage clear");
    a_pwr_wait: assert property (
        $rose(rst_b) |-> state_q == tsg_pkg::ST_POWERUP [*3])
        else $error("power-up judged before inputs settled");
endmodule // tsg_trip_guard

// *** testbench/tsg_contacts.sv ***
// external contacts model: terminals, run, reset, keypad, undervoltage
`timescale 1ns/1ps
module tsg_contacts (
    // clock
    input wire logic clk,
    // contact levels toward the drive
    output logic [4:0] term_in,
    output logic run_cmd,
    output logic rst_term_in,
    output logic key_in,
    output logic uv_in
);
    initial begin
        term_in = 5'h00;
        run_cmd = 1'b0;
        rst_term_in = 1'b0;
        key_in = 1'b0;
        uv_in = 1'b0;
    end
    // contacts move on the falling edge, away from the sampling edge
    task automatic drive(input logic [4:0] t, input logic r, input logic s,
                         input logic k, input logic u);
        @(negedge clk);
        term_in = t;
        run_cmd = r;
        rst_term_in = s;
        key_in = k;
        uv_in = u;
    endtask
endmodule // tsg_contacts

// *** testbench/trip_and_start_guard_bench.sv ***
// self-checking bench of the trip and start guard
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module trip_and_start_guard_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] term_in;
    logic run_cmd, rst_term_in, key_in, uv_in;
    logic drive_en, coast, alarm_out, guard_active;
    logic [7:0] err_code;
    logic [31:0] hist_flat;
    logic [2:0] hist_count;
    int miscompares = 0;
    int n_tests = 0;
    // terminal 0 is the fault input, terminal 1 the start guard
    logic [39:0] term_func = {24'h000000, tsg_pkg::FUNC_GUARD,
                              tsg_pkg::FUNC_FAULT};

    always #4 clk = ~clk;

    tsg_contacts u_pins (
        .clk(clk),
        .term_in(term_in),
        .run_cmd(run_cmd),
        .rst_term_in(rst_term_in),
        .key_in(key_in),
        .uv_in(uv_in)
    );

    tsg_trip_guard #(.N_TERM(5), .HIST_DEPTH(4)) u_dut (
        .clk(clk),
        .rst_b(rst_b),
        .term_in(term_in),
        .term_func(term_func),
        .run_cmd(run_cmd),
        .reset_terminal_input(rst_term_in),
        .keypad_reset(key_in),
        .uv_fault(uv_in),
        .drive_en(drive_en),
        .coast(coast),
        .alarm_out(alarm_out),
        .guard_active(guard_active),
        .err_code(err_code),
        .hist_flat(hist_flat),
        .hist_count(hist_count)
    );

    task automatic pins(input logic [4:0] t, input logic r, input logic s,
                        input logic k, input logic u);
        u_pins.drive(t, r, s, k, u);
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic chk_st(input logic en, input logic al,
                          input logic [7:0] er);
        `CHK(drive_en, en)
        `CHK(alarm_out, al)
        `CHK(err_code, er)
    endtask

    // power cycle: reset held 4 cycles with the given levels present
    task automatic pwr(input logic run, input logic guard);
        u_pins.drive({3'h0, guard, 1'b0}, run, 1'b0, 1'b0, 1'b0);
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task automatic t_run_trip;
        int n;
        pwr(1'b1, 1'b0);
        chk_st(1'b1, 1'b0, tsg_pkg::ERR_NONE);
        u_pins.drive(5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
        n = 0;
        while (alarm_out !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n >= 2 && n <= 4, 1'b1)
        `CHK({coast, drive_en}, 2'b10)
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_FAULT);
        `CHK(hist_flat[7:0], tsg_pkg::ERR_FAULT)
        pins(5'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        pins(5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_FAULT);
        `CHK(hist_count, 3'h1)
        pins(5'h01, 1'b1, 1'b1, 1'b0, 1'b0);
        chk_st(1'b0, 1'b0, tsg_pkg::ERR_NONE);
        `CHK(hist_count, 3'h0)
        pins(5'h01, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b1, 1'b0, tsg_pkg::ERR_NONE);
    endtask

    task automatic t_stop_trip;
        pwr(1'b0, 1'b0);
        chk_st(1'b0, 1'b0, tsg_pkg::ERR_NONE);
        pins(5'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_FAULT);
        pins(5'h01, 1'b0, 1'b0, 1'b1, 1'b0);
        pins(5'h01, 1'b0, 1'b0, 1'b0, 1'b0);
        chk_st(1'b0, 1'b0, tsg_pkg::ERR_NONE);
        `CHK(coast, 1'b0)
    endtask

    task automatic t_guard_pwr;
        pwr(1'b1, 1'b1);
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_GUARD);
        `CHK(guard_active, 1'b1)
        pins(5'h02, 1'b0, 1'b0, 1'b0, 1'b0);
        chk_st(1'b0, 1'b0, tsg_pkg::ERR_NONE);
        pins(5'h02, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b1, 1'b0, tsg_pkg::ERR_NONE);
        // run off is no reset, so the guard record stays and shifts up
        pins(5'h03, 1'b1, 1'b0, 1'b0, 1'b0);
        `CHK(hist_count, 3'h2)
        `CHK(hist_flat[15:8], tsg_pkg::ERR_GUARD)
        `CHK(hist_flat[7:0], tsg_pkg::ERR_FAULT)
    endtask

    task automatic t_guard_rst;
        pwr(1'b1, 1'b1);
        pins(5'h02, 1'b1, 1'b1, 1'b0, 1'b0);
        pins(5'h02, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b1, 1'b0, tsg_pkg::ERR_NONE);
    endtask

    task automatic t_uv;
        pwr(1'b1, 1'b0);
        pins(5'h02, 1'b1, 1'b0, 1'b0, 1'b1);
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_UV);
        pins(5'h02, 1'b1, 1'b1, 1'b0, 1'b0);
        pins(5'h02, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_GUARD);
    endtask

    task automatic t_guard_fault;
        pwr(1'b0, 1'b1);
        chk_st(1'b0, 1'b0, tsg_pkg::ERR_NONE);
        pins(5'h02, 1'b1, 1'b0, 1'b0, 1'b0);
        pins(5'h03, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b0, 1'b1, tsg_pkg::ERR_FAULT);
        pins(5'h03, 1'b1, 1'b0, 1'b1, 1'b0);
        pins(5'h03, 1'b1, 1'b0, 1'b0, 1'b0);
        chk_st(1'b1, 1'b0, tsg_pkg::ERR_NONE);
    endtask

    task automatic report_and_stop;
        $display("tests=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // whole run is under two hundred cycles; over twenty-five times that means a hang
    initial begin
        #40000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        t_run_trip();
        t_stop_trip();
        t_guard_pwr();
        t_guard_rst();
        t_uv();
        t_guard_fault();
        report_and_stop();
    end
endmodule // trip_and_start_guard_bench
